// file: logic/flash_cp_seq.sv
// Module: command sequencer for continuous program, power-down and identifier reads
`timescale 1ns/1ns
`default_nettype none
module flash_cp_seq
   import flash_cp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        selPin_n,
   input  wire logic        sclkPin,
   input  wire logic        dinPin,
   output logic             doutPin,
   output logic             doutOe,
   input  wire logic        hwReset_n,
   input  wire logic        pageProtected,
   input  wire logic        progFail,
   output logic             progStrobe,
   output logic [23:0]      progAddr,
   output logic [7:0]       progEven,
   output logic [7:0]       progOdd,
   output logic             powerDown,
   output logic             writeInProgress
);
   flash_link_if lnk ();
   flash_link_sync uSync (
      .clock   (clock),
      .reset_n (reset_n),
      .selPin_n(selPin_n),
      .sclkPin (sclkPin),
      .dinPin  (dinPin),
      .lnk     (lnk)
   );
   // ----------------------------------------
   // State
   // ----------------------------------------
   phase_t      ph_ff, nxt_ph;          // Frame phase
   logic [7:0]  opc_ff, nxt_opc;        // Opcode of frame
   logic [7:0]  sh_ff, nxt_sh;          // Input shifter
   logic [2:0]  bit_ff, nxt_bit;        // Bit in byte
   logic [2:0]  byt_ff, nxt_byt;        // Bytes after opcode
   logic [23:0] addr_ff, nxt_addr;      // Program address
   logic [7:0]  b0_ff, nxt_b0;          // Even data byte
   logic [7:0]  b1_ff, nxt_b1;          // Odd data byte
   logic        wel_ff, nxt_wel;        // Write enable latch
   logic        cp_ff, nxt_cp;          // Continuous program mode
   logic        rbo_ff, nxt_rbo;        // Ready/busy output on
   logic        rstArm_ff, nxt_rstArm;  // Reset enable armed
   logic        pd_ff, nxt_pd;          // Deep power-down
   logic        wip_ff, nxt_wip;        // Write in progress
   logic [15:0] tmr_ff, nxt_tmr;        // Shared delay counter
   logic [1:0]  tk_ff, nxt_tk;          // Timer job: 1 prog, 2 entry, 3 release
   logic [7:0]  out_ff, nxt_out;        // Output shifter
   logic        odd_ff, nxt_odd;        // Identifier alternation
   logic        do_ff, nxt_do;          // Data-out level
   logic        oe_ff, nxt_oe;          // Data-out enable
   logic        pulse_ff, nxt_pulse;    // Program strobe
   logic        fail_ff, nxt_fail;      // Last program failed
   logic        hr1_ff, hr2_ff;         // Hardware reset synchroniser

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hr1_ff <= 1'b1;
         hr2_ff <= 1'b1;
      end else begin
         hr1_ff <= hwReset_n;
         hr2_ff <= hr1_ff;
      end
   end

   // Status and security registers built from live state
   logic [7:0] statusReg, secReg, byteIn;
   logic       okInCp, idOp;
   assign statusReg = {6'h00, wel_ff, wip_ff};
   assign secReg    = {1'b0, 1'b0, fail_ff, cp_ff, 4'h0};  // Bit four mode flag
   assign byteIn    = {sh_ff[6:0], lnk.dataIn};
   assign idOp      = (byteIn == OP_ID1_C) || (byteIn == OP_ID2_C) || (byteIn == OP_ID4_C);
   // Filter for the restricted command set in the mode
   assign okInCp = (byteIn == OP_CPRG_C) || (byteIn == OP_WRITE_DISABLE_CMD_C) || (byteIn == OP_READ_STATUS_CMD_C) ||
                   (byteIn == OP_RDSCR_C) || (byteIn == OP_RSTE_C) || (byteIn == OP_RSTX_C);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      nxt_ph = ph_ff;  nxt_opc = opc_ff;  nxt_sh = sh_ff;  nxt_bit = bit_ff;
      nxt_byt = byt_ff;  nxt_addr = addr_ff;  nxt_b0 = b0_ff;  nxt_b1 = b1_ff;
      nxt_wel = wel_ff;  nxt_cp = cp_ff;  nxt_rbo = rbo_ff;  nxt_rstArm = rstArm_ff;
      nxt_pd = pd_ff;  nxt_wip = wip_ff;  nxt_tmr = tmr_ff;  nxt_tk = tk_ff;
      nxt_out = out_ff;  nxt_odd = odd_ff;  nxt_do = do_ff;  nxt_oe = oe_ff;
      nxt_pulse = 1'b0;  nxt_fail = fail_ff;
      // Self-timed jobs
      if (tk_ff != 2'd0) begin
         if (tmr_ff != 16'h0) begin
            nxt_tmr = tmr_ff - 16'h1;
         end else begin
            nxt_tk = 2'd0;
            if (tk_ff == 2'd1) begin
               nxt_wip = 1'b0;  // Busy ends with the pair
               nxt_pulse = ~pageProtected;
               nxt_fail = progFail | pageProtected;
               nxt_wel = cp_ff & ~pageProtected & (addr_ff != TOP_ADDR_C - 24'h1);
               // Address stays put so the strobe names this pair
               if (pageProtected || addr_ff == TOP_ADDR_C - 24'h1) begin
                  nxt_cp = 1'b0;  // No wrap, leave mode
               end
            end else if (tk_ff == 2'd2) begin
               nxt_pd = 1'b1;  // Entry delay elapsed
            end else begin
               nxt_pd = 1'b0;  // Release delay elapsed
            end
         end
      end
      // Frame start: ready/busy drive or idle
      if (lnk.selFall) begin
         nxt_ph = ST_OPC;  nxt_bit = 3'd0;  nxt_byt = 3'd0;
         nxt_oe = cp_ff & rbo_ff;  nxt_do = ~wip_ff;  // Low busy, high ready
      end
      // Input bit sampled on rising serial clock; output phase counts falls only
      if (lnk.rise && ph_ff != ST_SKIP && ph_ff != ST_OUT) begin
         nxt_sh = byteIn;
         nxt_bit = bit_ff + 3'd1;
         if (bit_ff == 3'd7) begin
            if (ph_ff == ST_OPC) begin
               nxt_opc = byteIn;
               nxt_ph = ST_SKIP;
               if (pd_ff) begin
                  // Only release and signature survive
                  if (byteIn == OP_REL_C && !wip_ff) begin
                     nxt_ph = ST_OUT;  nxt_out = SIG_ID_C;
                  end
               end else if (cp_ff && !okInCp) begin
                  nxt_ph = ST_SKIP;
               end else if (byteIn == OP_REL_C) begin
                  if (!wip_ff) begin
                     nxt_ph = ST_OUT;  nxt_out = SIG_ID_C;
                  end
               end else if (byteIn == OP_READ_STATUS_CMD_C) begin
                  nxt_ph = ST_OUT;  nxt_out = statusReg;
               end else if (byteIn == OP_RDSCR_C) begin
                  nxt_ph = ST_OUT;  nxt_out = secReg;
               end else if (idOp || byteIn == OP_CPRG_C) begin
                  nxt_ph = (byteIn == OP_CPRG_C && cp_ff) ? ST_DATA : ST_ADDR;
               end
               if (byteIn == OP_RSTX_C && rstArm_ff && !pd_ff) begin
                  nxt_cp = 1'b0;  nxt_wel = 1'b0;  // Software reset ends mode
               end
               nxt_rstArm = (byteIn == OP_RSTE_C) && !pd_ff;
            end else if (ph_ff == ST_ADDR) begin
               nxt_byt = byt_ff + 3'd1;
               if (opc_ff == OP_CPRG_C) begin
                  nxt_addr = {addr_ff[15:0], byteIn};
               end
               if (byt_ff == 3'd2) begin
                  if (opc_ff == OP_CPRG_C) begin
                     nxt_ph = ST_DATA;  nxt_byt = 3'd0;
                  end else begin
                     // Address bit zero orders the identifiers
                     nxt_ph = ST_OUT;
                     nxt_out = byteIn[0] ? DEV_ID_C : MAKER_ID_C;
                     nxt_odd = byteIn[0];
                  end
               end
            end else if (ph_ff == ST_DATA) begin
               // First byte even, second odd, rest ignored
               if (byt_ff == 3'd0) begin
                  nxt_b0 = byteIn;
               end else if (byt_ff == 3'd1) begin
                  nxt_b1 = byteIn;
               end
               if (byt_ff != 3'd7) begin
                  nxt_byt = byt_ff + 3'd1;
               end
            end
         end
      end
      // Output shifted on falling serial clock, MSB first
      if (lnk.fall && ph_ff == ST_OUT) begin
         nxt_oe = 1'b1;
         nxt_do = out_ff[7];
         nxt_out = {out_ff[6:0], out_ff[7]};
         nxt_bit = bit_ff + 3'd1;
         if (bit_ff == 3'd7 && (opc_ff == OP_ID1_C || opc_ff == OP_ID2_C || opc_ff == OP_ID4_C)) begin
            nxt_odd = ~odd_ff;  // Alternate identifiers
            nxt_out = odd_ff ? MAKER_ID_C : DEV_ID_C;
         end else if (bit_ff == 3'd7 && opc_ff == OP_READ_STATUS_CMD_C) begin
            nxt_out = statusReg;
         end
      end
      // Frame end: execute commands taken at select rise
      if (lnk.selRise) begin
         nxt_oe = 1'b0;  nxt_ph = ST_SKIP;
         // Output frames see one extra fall after the opcode, hence bit one
         if (((ph_ff == ST_SKIP && bit_ff == 3'd0) || (ph_ff == ST_OUT && bit_ff == 3'd1)) && !wip_ff) begin
            if (pd_ff) begin
               if (opc_ff == OP_REL_C) begin
                  nxt_tk = 2'd3;  nxt_tmr = 16'(RES_CYC_C - 1);  // Release delay
               end
            end else if (opc_ff == OP_WRITE_ENABLE_CMD_C && !cp_ff) begin
               nxt_wel = 1'b1;
            end else if (opc_ff == OP_WRITE_DISABLE_CMD_C) begin
               nxt_wel = 1'b0;  nxt_cp = 1'b0;  // Only when idle
            end else if (opc_ff == OP_RBON_C && !cp_ff) begin
               nxt_rbo = 1'b1;
            end else if (opc_ff == OP_RBOFF_C && !cp_ff) begin
               nxt_rbo = 1'b0;
            end else if (opc_ff == OP_PDN_C && !cp_ff) begin
               nxt_tk = 2'd2;  nxt_tmr = 16'(DP_CYC_C - 1);
            end
         end
         if (ph_ff == ST_DATA && bit_ff == 3'd0 && byt_ff >= 3'd2 && !wip_ff && (cp_ff || wel_ff)) begin
            // Latch required to enter the mode
            nxt_cp = 1'b1;  nxt_wip = 1'b1;  nxt_tk = 2'd1;
            if (cp_ff) begin
               nxt_addr = addr_ff + 24'h2;  // Next pair address
            end
            nxt_tmr = 16'(BP_CYC_C - 1);
         end
      end
      if (!hr2_ff) begin
         nxt_cp = 1'b0;  nxt_wel = 1'b0;  nxt_ph = ST_SKIP;  // Hardware reset ends mode
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ph_ff <= ST_SKIP;  opc_ff <= 8'h00;  sh_ff <= 8'h00;  bit_ff <= 3'd0;
         byt_ff <= 3'd0;  addr_ff <= 24'h000000;  b0_ff <= 8'hff;  b1_ff <= 8'hff;
         wel_ff <= 1'b0;  cp_ff <= 1'b0;  rbo_ff <= 1'b0;  rstArm_ff <= 1'b0;
         pd_ff <= 1'b0;  wip_ff <= 1'b0;  tmr_ff <= 16'h0;  tk_ff <= 2'd0;
         out_ff <= 8'h00;  odd_ff <= 1'b0;  do_ff <= 1'b0;  oe_ff <= 1'b0;
         pulse_ff <= 1'b0;  fail_ff <= 1'b0;
      end else begin
         ph_ff <= nxt_ph;  opc_ff <= nxt_opc;  sh_ff <= nxt_sh;  bit_ff <= nxt_bit;
         byt_ff <= nxt_byt;  addr_ff <= nxt_addr;  b0_ff <= nxt_b0;  b1_ff <= nxt_b1;
         wel_ff <= nxt_wel;  cp_ff <= nxt_cp;  rbo_ff <= nxt_rbo;  rstArm_ff <= nxt_rstArm;
         pd_ff <= nxt_pd;  wip_ff <= nxt_wip;  tmr_ff <= nxt_tmr;  tk_ff <= nxt_tk;
         out_ff <= nxt_out;  odd_ff <= nxt_odd;  do_ff <= nxt_do;  oe_ff <= nxt_oe;
         pulse_ff <= nxt_pulse;  fail_ff <= nxt_fail;
      end
   end

   assign doutPin         = do_ff;
   assign doutOe          = oe_ff;
   assign progStrobe      = pulse_ff;
   assign progAddr        = addr_ff;
   assign progEven        = b0_ff;
   assign progOdd         = b1_ff;
   assign powerDown       = pd_ff;
   assign writeInProgress = wip_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_CP_NEEDS_WEL: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(cp_ff) |-> $past(wel_ff)) else $error("mode entered without latch");
   AST_WIP_PAIR: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(wip_ff) |-> wip_ff [*8]) else $error("busy ended too soon");
   AST_WIP_END: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(wip_ff) |-> ##[1:250] !wip_ff) else $error("busy never ended");
   AST_INDICATOR: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(secReg[SCR_CP_C]) |-> $past(lnk.selRise && ph_ff == ST_DATA)) else $error("indicator wrong");
   AST_PROT_WEL: assert property (@(posedge clock) disable iff (!reset_n)
      (tk_ff == 2'd1 && tmr_ff == 16'h0 && pageProtected) |=> !wel_ff && !progStrobe)
      else $error("protected page programmed");
   AST_PD_DELAY: assert property (@(posedge clock) disable iff (!reset_n)
      (lnk.selRise && !pd_ff && tk_ff == 2'd0) |=> !pd_ff [*2]) else $error("power-down too early");
   AST_RB_DRIVE: assert property (@(posedge clock) disable iff (!reset_n)
      (lnk.selFall && cp_ff && rbo_ff) |=> doutOe && (doutPin == !$past(wip_ff)))
      else $error("ready/busy not driven");
   AST_TRISTATE: assert property (@(posedge clock) disable iff (!reset_n)
      lnk.selRise |=> !doutOe) else $error("pin driven while deselected");
   AST_NO_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
      (progStrobe && progAddr == TOP_ADDR_C - 24'h1) |-> !cp_ff) else $error("address wrapped");
   COV_CP: cover property (@(posedge clock) disable iff (!reset_n) $rose(cp_ff));
   COV_PD: cover property (@(posedge clock) disable iff (!reset_n) $rose(pd_ff));
   COV_REL: cover property (@(posedge clock) disable iff (!reset_n) $fell(pd_ff));
endmodule
`default_nettype wire

// file: logic/flash_cp_pkg.sv
// Package: opcodes, status and security bit positions, timing counts for the flash sequencer
package flash_cp_pkg;
   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE_CMD_C  = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE_CMD_C  = 8'h04;
   localparam logic [7:0] OP_READ_STATUS_CMD_C  = 8'h05;
   localparam logic [7:0] OP_RDSCR_C = 8'h2b;
   localparam logic [7:0] OP_CPRG_C  = 8'had;
   localparam logic [7:0] OP_RSTE_C  = 8'h66;
   localparam logic [7:0] OP_RSTX_C  = 8'h99;
   localparam logic [7:0] OP_RBON_C  = 8'h70;
   localparam logic [7:0] OP_RBOFF_C = 8'h80;
   localparam logic [7:0] OP_PDN_C   = 8'hb9;
   localparam logic [7:0] OP_REL_C   = 8'hab;
   localparam logic [7:0] OP_ID1_C   = 8'h90;
   localparam logic [7:0] OP_ID2_C   = 8'hdf;
   localparam logic [7:0] OP_ID4_C   = 8'hef;
   // ----------------------------------------
   // Register bit positions and identities
   // ----------------------------------------
   localparam int SR_WIP_C   = 0;
   localparam int SR_WEL_C   = 1;
   localparam int SCR_CP_C   = 4;
   localparam logic [7:0] MAKER_ID_C = 8'h5a;  // Arbitrary value
   localparam logic [7:0] DEV_ID_C   = 8'h3c;  // Arbitrary value
   localparam logic [7:0] SIG_ID_C   = 8'h3c;  // Arbitrary value
   localparam logic [23:0] TOP_ADDR_C = 24'hffffff;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS_C     = 40;
   localparam int T_BP_NS_C    = 8000;
   localparam int T_DP_NS_C    = 3000;
   localparam int T_RES2_NS_C  = 8800;
   localparam int BP_CYC_C     = (T_BP_NS_C + CLK_NS_C - 1) / CLK_NS_C;
   localparam int DP_CYC_C     = (T_DP_NS_C + CLK_NS_C - 1) / CLK_NS_C;
   localparam int RES_CYC_C    = T_RES2_NS_C / CLK_NS_C;
   typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DATA, ST_OUT, ST_SKIP} phase_t;
endpackage

// file: logic/flash_link_if.sv
// Interface: bit events from the link front end to the command sequencer
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
   logic selLow;    // Chip select low, synchronised
   logic selRise;   // Chip select rising pulse
   logic selFall;   // Chip select falling pulse
   logic rise;      // Sample strobe, serial clock rising
   logic fall;      // Shift strobe, serial clock falling
   logic dataIn;    // Input data bit, synchronised
   modport front (output selLow, selRise, selFall, rise, fall, dataIn);
   modport core  (input selLow, selRise, selFall, rise, fall, dataIn);
endinterface
`default_nettype wire

// file: logic/flash_link_sync.sv
// Module: pin synchroniser and edge finder for the serial link
`timescale 1ns/1ns
`default_nettype none
module flash_link_sync (
   input  wire logic  clock,
   input  wire logic  reset_n,
   input  wire logic  selPin_n,
   input  wire logic  sclkPin,
   input  wire logic  dinPin,
   flash_link_if.front lnk
);
   // ----------------------------------------
   // Two-stage synchronisers, then one history stage
   // ----------------------------------------
   logic [2:0] s1_ff, s2_ff, s3_ff;  // Stages for select, clock, data
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= 3'h7;
         s2_ff <= 3'h7;
         s3_ff <= 3'h7;
      end else begin
         s1_ff <= {selPin_n, sclkPin, dinPin};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   // Edges from second and third stages only
   assign lnk.selLow  = ~s2_ff[2];
   assign lnk.selRise = s2_ff[2] & ~s3_ff[2];
   assign lnk.selFall = ~s2_ff[2] & s3_ff[2];
   assign lnk.rise    = ~s2_ff[2] & s2_ff[1] & ~s3_ff[1];
   assign lnk.fall    = ~s2_ff[2] & ~s2_ff[1] & s3_ff[1];
   assign lnk.dataIn  = s2_ff[0];
endmodule
`default_nettype wire

// file: verification/host_spi_model.sv
// Host serial controller model: drives select, serial clock and data in
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
   input  wire logic clock,
   input  wire logic soLine,
   output logic      selPin_n,
   output logic      sclkPin,
   output logic      dinPin
);
   typedef logic [7:0] byte_q_t[$];
   logic [7:0] rxByte;  // Byte being shifted in
   logic [7:0] rxQ[$];  // Bytes read in the last frame
   // ------------------------------
   // Idle: deselected, clock parked low
   // ------------------------------
   initial begin
      selPin_n = 1'h1;
      sclkPin  = 1'h0;
      dinPin   = 1'h0;
      rxByte   = 8'h00;
   end
   // One bit per 8 clocks; sampled late so the device has settled
   task automatic shift(input logic [7:0] tx, input int nBits);
      for (int i = 7; i > 7 - nBits; i--) begin
         dinPin = tx[i];
         repeat (4) @(negedge clock);
         sclkPin = 1'h1;
         repeat (4) @(negedge clock);
         rxByte  = {rxByte[6:0], soLine};
         sclkPin = 1'h0;
      end
   endtask
   // Whole frame; nOdd extra bits break byte alignment on purpose
   task automatic frame(input byte_q_t tx, input int nRd, input int nOdd);
      rxQ = {};
      selPin_n = 1'h0;
      repeat (4) @(negedge clock);
      foreach (tx[i]) shift(tx[i], 8);
      for (int i = 0; i < nRd; i++) begin
         shift(8'h00, 8);
         rxQ.push_back(rxByte);
      end
      if (nOdd > 0) shift(8'h00, nOdd);
      repeat (4) @(negedge clock);
      selPin_n = 1'h1;
      dinPin   = ~dinPin;  // Released line carries no stale bit
      repeat (8) @(negedge clock);
   endtask
endmodule
`default_nettype wire

// file: verification/test_flash_cp_seq.sv
// Testbench for the continuous program, power-down and identifier sequencer
`timescale 1ns/1ns
`default_nettype none
module test_flash_cp_seq
   import flash_cp_pkg::*;
;
   logic        clock, reset_n, hwReset_n;     // Clock and resets
   logic        pageProtected, progFail;       // Array answers
   wire logic   selPin_n, sclkPin, dinPin;     // From the host model
   logic        doutPin, doutOe, progStrobe, powerDown, writeInProgress;
   logic [23:0] progAddr, gA;                  // Program address, captured
   logic [7:0]  progEven, progOdd, gE, gO;     // Program data, captured
   logic        lastSo, oeSeen;                // Held level, drive seen
   wire logic   soLine = doutOe ? doutPin : ~lastSo;  // Undriven wire drifts
   int          errors, n_tests;
   // ------------------------------
   // Clock, wire watch, instances
   // ------------------------------
   always #20 clock = ~clock;
   always @(posedge clock) begin
      if (doutOe === 1'h1) begin
         lastSo <= doutPin;
         oeSeen <= 1'h1;
      end
   end
   flash_cp_seq uut (.clock(clock), .reset_n(reset_n), .selPin_n(selPin_n), .sclkPin(sclkPin),
      .dinPin(dinPin), .doutPin(doutPin), .doutOe(doutOe), .hwReset_n(hwReset_n),
      .pageProtected(pageProtected), .progFail(progFail), .progStrobe(progStrobe),
      .progAddr(progAddr), .progEven(progEven), .progOdd(progOdd), .powerDown(powerDown),
      .writeInProgress(writeInProgress));
   host_spi_model host (.clock(clock), .soLine(soLine), .selPin_n(selPin_n),
      .sclkPin(sclkPin), .dinPin(dinPin));
   // ------------------------------
   // Shared helpers
   // ------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdReg(input logic [7:0] op, output logic [7:0] v);
      host.frame('{op}, 1, 0);
      v = host.rxQ[0];
   endtask
   // Watch for a program strobe, then for busy to drop
   task automatic waitProg(input logic expSeen);
      logic seen;
      seen = 1'h0;
      for (int i = 0; i < BP_CYC_C + 60; i++) begin
         @(posedge clock);
         #1;
         if (progStrobe === 1'h1) begin
            seen = 1'h1;
            gA = progAddr;
            gE = progEven;
            gO = progOdd;
         end
         if (seen && writeInProgress === 1'h0) break;
      end
      chk(24'(seen), 24'(expSeen));
      @(negedge clock);
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_nolatch();
      logic [7:0] v;
      host.frame('{OP_CPRG_C, 8'h00, 8'h00, 8'h10, 8'h12, 8'h34}, 0, 0);
      waitProg(1'h0);
      rdReg(OP_RDSCR_C, v);
      chk(24'(v[SCR_CP_C]), 24'h0);
      $display("no latch test done");
   endtask
   task automatic t_pairs();
      logic [7:0] v;
      host.frame('{OP_WRITE_ENABLE_CMD_C}, 0, 0);
      host.frame('{OP_CPRG_C, 8'h00, 8'h01, 8'h00, 8'ha1, 8'hb2}, 0, 0);
      chk(24'(writeInProgress), 24'h1);
      waitProg(1'h1);
      chk(gA, 24'h000100);
      chk(24'({gE, gO}), 24'h00a1b2);
      rdReg(OP_RDSCR_C, v);
      chk(24'(v[SCR_CP_C]), 24'h1);
      oeSeen = 1'h0;
      host.frame('{OP_ID1_C, 8'h00, 8'h00, 8'h00}, 2, 0);
      chk(24'(oeSeen), 24'h0);
      host.frame('{OP_CPRG_C, 8'hc3, 8'hd4}, 0, 0);
      waitProg(1'h1);
      chk(24'({gA[7:0], gE, gO}), 24'h02c3d4);
      host.frame('{OP_CPRG_C, 8'h55}, 0, 0);
      waitProg(1'h0);
      host.frame('{OP_CPRG_C, 8'he5, 8'hf6, 8'h77}, 0, 0);
      waitProg(1'h1);
      chk(24'({gA[7:0], gE, gO}), 24'h04e5f6);
      host.frame('{OP_WRITE_DISABLE_CMD_C}, 0, 0);
      rdReg(OP_RDSCR_C, v);
      chk(24'(v[SCR_CP_C]), 24'h0);
      rdReg(OP_READ_STATUS_CMD_C, v);
      chk(24'(v[SR_WEL_C]), 24'h0);
      $display("pairs test done");
   endtask
   task automatic t_pdown();
      logic [7:0] v;
      host.frame('{OP_PDN_C}, 0, 0);
      chk(24'(powerDown), 24'h0);
      repeat (DP_CYC_C) @(negedge clock);
      chk(24'(powerDown), 24'h1);
      host.frame('{OP_WRITE_ENABLE_CMD_C}, 0, 0);
      host.frame('{OP_REL_C}, 0, 3);
      repeat (RES_CYC_C + 20) @(negedge clock);
      chk(24'(powerDown), 24'h1);
      host.frame('{OP_REL_C}, 2, 0);
      chk(24'({host.rxQ[0], host.rxQ[1]}), 24'({SIG_ID_C, SIG_ID_C}));
      chk(24'(powerDown), 24'h1);
      repeat (RES_CYC_C + 20) @(negedge clock);
      chk(24'(powerDown), 24'h0);
      rdReg(OP_READ_STATUS_CMD_C, v);
      chk(24'(v[SR_WEL_C]), 24'h0);
      $display("power-down test done");
   endtask
   task automatic t_top();
      logic [7:0] v;
      host.frame('{OP_RBON_C}, 0, 0);
      host.frame('{OP_WRITE_ENABLE_CMD_C}, 0, 0);
      host.frame('{OP_CPRG_C, 8'hff, 8'hff, 8'hfc, 8'h11, 8'h22}, 0, 0);
      oeSeen = 1'h0;
      host.frame('{OP_WRITE_DISABLE_CMD_C}, 0, 0);
      chk(24'({oeSeen, lastSo}), 24'h2);
      waitProg(1'h1);
      rdReg(OP_RDSCR_C, v);
      chk(24'(v[SCR_CP_C]), 24'h1);
      host.frame('{OP_CPRG_C, 8'h33, 8'h44}, 0, 0);
      waitProg(1'h1);
      chk(gA, TOP_ADDR_C - 24'h1);
      rdReg(OP_RDSCR_C, v);
      chk(24'(v[SCR_CP_C]), 24'h0);
      rdReg(OP_READ_STATUS_CMD_C, v);
      chk(24'(v[SR_WEL_C]), 24'h0);
      host.frame('{OP_RBOFF_C}, 0, 0);
      $display("top address test done");
   endtask
   task automatic t_prot();
      logic [7:0] v;
      host.frame('{OP_WRITE_ENABLE_CMD_C}, 0, 0);
      host.frame('{OP_CPRG_C, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02}, 0, 0);
      waitProg(1'h1);
      hwReset_n = 1'h0;
      repeat (4) @(negedge clock);
      hwReset_n = 1'h1;
      repeat (8) @(negedge clock);
      rdReg(OP_RDSCR_C, v);
      chk(24'(v[SCR_CP_C]), 24'h0);
      host.frame('{OP_WRITE_ENABLE_CMD_C}, 0, 0);
      pageProtected = 1'h1;
      host.frame('{OP_CPRG_C, 8'h00, 8'h04, 8'h00, 8'h99, 8'h88}, 0, 0);
      waitProg(1'h0);
      rdReg(OP_READ_STATUS_CMD_C, v);
      chk(24'(v[SR_WEL_C]), 24'h0);
      pageProtected = 1'h0;
      $display("protect test done");
   endtask
   task automatic t_ids();
      logic [7:0] ops[3] = '{OP_ID1_C, OP_ID2_C, OP_ID4_C};
      foreach (ops[k]) begin
         for (int a = 0; a < 2; a++) begin
            host.frame('{ops[k], 8'h00, 8'h00, 8'(8'h02 + a)}, 3, 0);
            chk({host.rxQ[0], host.rxQ[1], host.rxQ[2]}, (a == 0) ? {MAKER_ID_C, DEV_ID_C,
               MAKER_ID_C} : {DEV_ID_C, MAKER_ID_C, DEV_ID_C});
         end
      end
      $display("identifier test done");
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial begin
      clock = 1'h0;
      reset_n = 1'h0;
      hwReset_n = 1'h1;
      pageProtected = 1'h0;
      progFail = 1'h0;
      lastSo = 1'h0;
      oeSeen = 1'h0;
      errors = 0;
      n_tests = 0;
      repeat (8) @(negedge clock);
      reset_n = 1'h1;
      repeat (4) @(negedge clock);
      t_nolatch();
      t_pairs();
      t_pdown();
      t_top();
      t_prot();
      t_ids();
      end_of_test();
   end
   // About five times the expected run
   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
